// *** core/mwt_pkg.sv ***
package mwt_pkg;

  // Clock period of the timing logic.
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // Documented times, each in its own unit.
  localparam int unsigned T_RESET_DELAY_MS = 8;
  localparam int unsigned T_POWER_UP_MAX_MS = 70;
  localparam int unsigned T_STBY_NORMAL_MAX_MS = 10;
  localparam int unsigned T_SLEEP_STBY_MAX_MS = 50;
  localparam int unsigned T_DOM_WAKE_MIN_NS = 5000;
  localparam int unsigned T_REC_WAKE_MIN_NS = 5000;
  localparam int unsigned T_REMOTE_WAKE_NS = 24000;
  localparam int unsigned T_LOCAL_WAKE_NS = 32000;
  localparam int unsigned T_WAKE_FILT_MIN_NS = 750;
  localparam int unsigned T_WAKE_FILT_MAX_NS = 5000;
  localparam int unsigned T_DOM_TIMEOUT_US = 1000;
  localparam int unsigned T_STARTUP_WD_MS = 300;

  // Cycle counts; least times round up, typical times round down.
  localparam int unsigned DOM_WAKE_CYC =
    (T_DOM_WAKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REC_WAKE_CYC =
    (T_REC_WAKE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKE_FILT_CYC =
    (T_WAKE_FILT_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned REMOTE_WAKE_CYC =
    T_REMOTE_WAKE_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned LOCAL_WAKE_CYC =
    T_LOCAL_WAKE_NS * 1000 / CLK_PERIOD_PS;
  localparam int unsigned DOM_TIMEOUT_CYC =
    T_DOM_TIMEOUT_US * 1000 / (CLK_PERIOD_PS / 1000);
  localparam int unsigned RESET_DELAY_CYC =
    T_RESET_DELAY_MS * 1000 * (1000 / (CLK_PERIOD_PS / 1000));
  localparam int unsigned STARTUP_WD_CYC =
    T_STARTUP_WD_MS * 1000 * (1000 / (CLK_PERIOD_PS / 1000));

  // Synchroniser lane positions.
  localparam int unsigned PIN_WAKE = 0;
  localparam int unsigned PIN_BUS = 1;
  localparam int unsigned PIN_TXD = 2;
  localparam int unsigned PIN_TRIG = 3;
  localparam int unsigned PIN_PGOOD = 4;
  localparam int unsigned PIN_N = 5;
  localparam logic [4:0] PIN_RESET = 5'h00;

  // Operating modes, one-hot.
  typedef enum logic [4:0] {
    MODE_RESET = 5'h01,
    MODE_STARTUP = 5'h02,
    MODE_STANDBY = 5'h04,
    MODE_NORMAL = 5'h08,
    MODE_SLEEP = 5'h10
  } mwt_mode_t;

  // Remote wake pattern progress.
  localparam logic [1:0] PAT_IDLE = 2'h0;
  localparam logic [1:0] PAT_DOM1 = 2'h1;
  localparam logic [1:0] PAT_REC = 2'h2;
  localparam logic [1:0] PAT_DONE = 2'h3;

endpackage

// *** core/mwt_core.sv ***
// Functional notes
// - Power-up reaches standby within 70 ms.
// - Standby to normal within 10 ms.
// - Wake in sleep reaches standby within 50 ms.
// - Dominant wake phase counts only after 5 us.
// - Recessive wake phase counts only after 5 us.
// - Remote wake flagged 24 us after pattern.
// - Local wake declared 32 us after pin edge.
// - Wake pin filter delay 0.75 to 5 us.
// - Transmit input dominant timeout near 1000 us.
// - Bus dominant clamp timeout near 1000 us.
// - Start-up watchdog allows 300 ms for trigger.
// - Trigger accepted only in 0.375..0.625 window, except in start-up where any trigger edge is accepted.
// - Sleep left only on remote or local wake.
// - Missed start-up trigger reasserts reset again.
module mwt_core #(
  parameter int unsigned RES_CYC = mwt_pkg::RESET_DELAY_CYC,
  parameter int unsigned STARTUP_CYC = mwt_pkg::STARTUP_WD_CYC,
  parameter int unsigned DOM_TO_CYC = mwt_pkg::DOM_TIMEOUT_CYC,
  parameter int unsigned REM_WAKE_CYC = mwt_pkg::REMOTE_WAKE_CYC,
  parameter int unsigned LOC_WAKE_CYC = mwt_pkg::LOCAL_WAKE_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Pins from outside the clock domain
  input wire logic power_good_i,
  input wire logic wake_pin_i,
  input wire logic bus_dominant_i,
  input wire logic txd_dominant_i,
  input wire logic wd_trigger_i,
  // Host commands and watchdog period, same clock
  input wire logic req_normal_i,
  input wire logic req_standby_i,
  input wire logic req_sleep_i,
  input wire logic [31:0] periodic_supervisor_period_i,
  // Mode and reset
  output logic [4:0] mode_o,
  output logic host_rst_n_o,
  output logic wd_fault_o,
  // Wake events
  output logic remote_wake_o,
  output logic local_wake_o,
  // Transmitter supervision
  output logic tx_enable_o,
  output logic tx_drive_dominant_o,
  output logic txd_timeout_o,
  output logic bus_timeout_o
);

  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: a change counts once stages two and three agree.

  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  logic [4:0] pin_q;
  wire [4:0] pins_raw = {wd_trigger_i, txd_dominant_i, bus_dominant_i,
                         wake_pin_i, power_good_i};
  wire [4:0] pins_in = {pins_raw[4], pins_raw[3], pins_raw[2],
                        pins_raw[1], pins_raw[0]};
  wire [4:0] pins_ordered = {pins_in[0], pins_in[4], pins_in[3],
                             pins_in[2], pins_in[1]};
  wire [4:0] next_pin_q = (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pin_s1 <= mwt_pkg::PIN_RESET;
      pin_s2 <= mwt_pkg::PIN_RESET;
      pin_s3 <= mwt_pkg::PIN_RESET;
      pin_q <= mwt_pkg::PIN_RESET;
    end else begin
      pin_s1 <= pins_ordered;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q <= next_pin_q;
    end
  end

  wire wake_q = pin_q[mwt_pkg::PIN_WAKE];
  wire bus_q = pin_q[mwt_pkg::PIN_BUS];
  wire txd_q = pin_q[mwt_pkg::PIN_TXD];
  wire trig_q = pin_q[mwt_pkg::PIN_TRIG];
  wire pgood_q = pin_q[mwt_pkg::PIN_PGOOD];

  //////////////////////////////////////////////////////////////////////////
  // Mode state and shared timer (reset delay, start-up and window).

  mwt_pkg::mwt_mode_t state;
  mwt_pkg::mwt_mode_t next_state;
  logic [31:0] tmr;
  logic [31:0] next_tmr;
  logic next_fault;
  logic wake_boot;
  logic trig_prev;
  wire trig_edge = trig_q & ~trig_prev;
  wire wake_any = remote_wake_o | local_wake_o;

  // Window bounds at 3/8 and 5/8 of the programmed period.
  wire [31:0] wp = periodic_supervisor_period_i;
  wire [33:0] wp3 = {2'h0, wp} + {1'b0, wp, 1'b0};
  wire [34:0] wp5 = {3'h0, wp} + {1'b0, wp, 2'h0};
  wire [31:0] win_lo = wp3[33:2] >> 1;
  wire [31:0] win_hi = wp5[34:3];
  wire in_window = (tmr >= win_lo) && (tmr <= win_hi);
  wire res_done = tmr >= RES_CYC - 32'h0000_0001;
  wire startup_done = tmr >= STARTUP_CYC - 32'h0000_0001;

  always_comb begin
    next_state = state;
    next_tmr = sat_inc(tmr);
    next_fault = 1'b0;
    case (state)
      mwt_pkg::MODE_RESET: begin
        if (!pgood_q) begin
          next_tmr = 32'h0000_0000;
        end else if (res_done) begin
          // A wake boot skips the start-up watchdog.
          next_state = wake_boot ? mwt_pkg::MODE_STANDBY
                                 : mwt_pkg::MODE_STARTUP;
          next_tmr = 32'h0000_0000;
        end
      end
      mwt_pkg::MODE_STARTUP: begin
        if (trig_edge) begin
          next_state = mwt_pkg::MODE_STANDBY;
          next_tmr = 32'h0000_0000;
        end else if (startup_done) begin
          next_state = mwt_pkg::MODE_RESET;
          next_tmr = 32'h0000_0000;
          next_fault = 1'b1;
        end
      end
      mwt_pkg::MODE_STANDBY, mwt_pkg::MODE_NORMAL: begin
        if ((trig_edge && !in_window) || (tmr > win_hi)) begin
          next_state = mwt_pkg::MODE_RESET;
          next_tmr = 32'h0000_0000;
          next_fault = 1'b1;
        end else begin
          if (trig_edge) begin
            next_tmr = 32'h0000_0000;
          end
          if (req_sleep_i) begin
            next_state = mwt_pkg::MODE_SLEEP;
          end else if (req_normal_i) begin
            next_state = mwt_pkg::MODE_NORMAL;
          end else if (req_standby_i) begin
            next_state = mwt_pkg::MODE_STANDBY;
          end
        end
      end
      mwt_pkg::MODE_SLEEP: begin
        next_tmr = 32'h0000_0000;
        if (wake_any) begin
          next_state = mwt_pkg::MODE_RESET;
        end
      end
      default: begin
        next_state = mwt_pkg::MODE_RESET;
        next_tmr = 32'h0000_0000;
      end
    endcase
    // Supply loss outside sleep restarts the reset delay.
    if (!pgood_q && state != mwt_pkg::MODE_SLEEP &&
        state != mwt_pkg::MODE_RESET) begin
      next_state = mwt_pkg::MODE_RESET;
      next_tmr = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state <= mwt_pkg::MODE_RESET;
      tmr <= 32'h0000_0000;
      wake_boot <= 1'b0;
      trig_prev <= 1'b0;
      wd_fault_o <= 1'b0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      wake_boot <= (state == mwt_pkg::MODE_SLEEP) ||
                   (state == mwt_pkg::MODE_RESET && wake_boot);
      trig_prev <= trig_q;
      wd_fault_o <= next_fault;
    end
  end

  assign mode_o = state;
  assign host_rst_n_o = (state != mwt_pkg::MODE_RESET);

  //////////////////////////////////////////////////////////////////////////
  // Remote wake: qualified dominant, recessive, dominant, then delay.

  wire lp_active = (state == mwt_pkg::MODE_STANDBY) ||
                   (state == mwt_pkg::MODE_SLEEP);
  logic bus_prev;
  logic [31:0] run_cnt;
  logic [1:0] pat;
  logic [31:0] rw_cnt;
  // Short pulses of the other level restart the run but keep progress.
  wire run_same = (bus_q == bus_prev);
  wire qual_dom = run_same && bus_q &&
                  (run_cnt == mwt_pkg::DOM_WAKE_CYC - 1);
  wire qual_rec = run_same && !bus_q &&
                  (run_cnt == mwt_pkg::REC_WAKE_CYC - 1);
  wire rw_fire = (pat == mwt_pkg::PAT_DONE) &&
                 (rw_cnt >= REM_WAKE_CYC - 32'h0000_0001);
  wire [1:0] next_pat =
    !lp_active ? mwt_pkg::PAT_IDLE :
    (pat == mwt_pkg::PAT_IDLE && qual_dom) ? mwt_pkg::PAT_DOM1 :
    (pat == mwt_pkg::PAT_DOM1 && qual_rec) ? mwt_pkg::PAT_REC :
    (pat == mwt_pkg::PAT_REC && qual_dom) ? mwt_pkg::PAT_DONE :
    rw_fire ? mwt_pkg::PAT_IDLE : pat;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bus_prev <= 1'b0;
      run_cnt <= 32'h0000_0000;
      pat <= mwt_pkg::PAT_IDLE;
      rw_cnt <= 32'h0000_0000;
      remote_wake_o <= 1'b0;
    end else begin
      bus_prev <= bus_q;
      run_cnt <= run_same ? sat_inc(run_cnt) : 32'h0000_0000;
      pat <= next_pat;
      rw_cnt <= (pat == mwt_pkg::PAT_DONE) ? sat_inc(rw_cnt)
                                           : 32'h0000_0000;
      remote_wake_o <= lp_active && rw_fire;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Local wake: stability filter, then a fixed detection delay.

  logic wake_f;
  logic [31:0] wf_cnt;
  logic lw_busy;
  logic [31:0] lw_cnt;
  wire wf_differ = (wake_q != wake_f);
  wire wf_take = wf_differ &&
                 (wf_cnt >= mwt_pkg::WAKE_FILT_CYC - 1);
  wire lw_fire = lw_busy && (lw_cnt >= LOC_WAKE_CYC - 32'h0000_0001);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wake_f <= 1'b0;
      wf_cnt <= 32'h0000_0000;
      lw_busy <= 1'b0;
      lw_cnt <= 32'h0000_0000;
      local_wake_o <= 1'b0;
    end else begin
      wake_f <= wf_take ? wake_q : wake_f;
      wf_cnt <= (wf_differ && !wf_take) ? sat_inc(wf_cnt)
                                        : 32'h0000_0000;
      lw_busy <= lp_active && (wf_take || (lw_busy && !lw_fire));
      lw_cnt <= (lw_busy && !wf_take) ? sat_inc(lw_cnt)
                                      : 32'h0000_0000;
      local_wake_o <= lp_active && lw_fire;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Dominant timeouts. Both latch until the transmit input is recessive,
  // so a stuck input cannot keep the bus dominant.

  logic [31:0] txd_cnt;
  logic [31:0] bus_cnt;
  wire txd_fire = txd_q && (txd_cnt >= DOM_TO_CYC - 32'h0000_0001);
  wire bus_fire = bus_q && (bus_cnt >= DOM_TO_CYC - 32'h0000_0001);
  wire tx_on = (state == mwt_pkg::MODE_NORMAL) &&
               !txd_timeout_o && !bus_timeout_o;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      txd_cnt <= 32'h0000_0000;
      bus_cnt <= 32'h0000_0000;
      txd_timeout_o <= 1'b0;
      bus_timeout_o <= 1'b0;
      tx_enable_o <= 1'b0;
      tx_drive_dominant_o <= 1'b0;
    end else begin
      txd_cnt <= txd_q ? sat_inc(txd_cnt) : 32'h0000_0000;
      bus_cnt <= bus_q ? sat_inc(bus_cnt) : 32'h0000_0000;
      txd_timeout_o <= txd_fire || (txd_timeout_o && txd_q);
      bus_timeout_o <= bus_fire || (bus_timeout_o && txd_q);
      tx_enable_o <= tx_on;
      tx_drive_dominant_o <= tx_on && txd_q && !txd_fire && !bus_fire;
    end
  end

endmodule

// *** verification/mwt_core_chk.sv ***
module mwt_chk #(
  parameter int unsigned DOM_TO_CYC = 300,
  parameter int unsigned REM_WAKE_CYC = 50,
  parameter int unsigned LOC_WAKE_CYC = 60
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Watched inputs
  input wire logic wake_pin_i,
  input wire logic bus_dominant_i,
  input wire logic txd_dominant_i,
  input wire logic req_normal_i,
  // Watched outputs
  input wire logic [4:0] mode_o,
  input wire logic host_rst_n_o,
  input wire logic wd_fault_o,
  input wire logic remote_wake_o,
  input wire logic local_wake_o,
  input wire logic tx_enable_o,
  input wire logic tx_drive_dominant_o,
  input wire logic txd_timeout_o,
  input wire logic bus_timeout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  //////////////////////////////////////////////////////////////////////////
  // Saturates so a stuck input cannot wrap round and hide a late timeout.
  logic [15:0] txd_run;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !txd_dominant_i) txd_run <= 16'h0000;
    else if (txd_run != 16'hFFFF) txd_run <= txd_run + 16'h0001;
  end
  //////////////////////////////////////////////////////////////////////////
  AST_HOST_RST: assert property (host_rst_n_o != mode_o[0])
    else $error("host reset does not follow reset mode");
  AST_FAULT: assert property (
    wd_fault_o |-> mode_o == 5'h01 ##1 !wd_fault_o)
    else $error("watchdog fault without reset mode");
  AST_NORMAL: assert property (
    mode_o == 5'h04 && req_normal_i |=> !mode_o[2])
    else $error("normal request left standby standing");
  AST_SLEEP: assert property (
    mode_o == 5'h10 && !remote_wake_o && !local_wake_o |=> mode_o == 5'h10)
    else $error("sleep left without a wake");
  AST_REMOTE: assert property (
    remote_wake_o |-> $past(bus_dominant_i, REM_WAKE_CYC + 10)
      && $past(bus_dominant_i, REM_WAKE_CYC + 900))
    else $error("remote wake without a long dominant phase");
  AST_LOCAL: assert property (
    local_wake_o |-> $past(wake_pin_i, LOC_WAKE_CYC + 10)
      == $past(wake_pin_i, LOC_WAKE_CYC + 140))
    else $error("local wake after an unsettled pin");
  AST_TXD_TO: assert property (
    txd_run > DOM_TO_CYC + 8 |-> txd_timeout_o)
    else $error("transmit timeout missing");
  AST_BUS_TO: assert property (
    $rose(bus_timeout_o) |-> $past(bus_dominant_i, DOM_TO_CYC - 2))
    else $error("bus timeout too early");
  AST_TX_OFF: assert property (
    txd_timeout_o && $past(txd_timeout_o)
      |-> !tx_enable_o && !tx_drive_dominant_o)
    else $error("transmitter active during timeout");
endmodule

bind mwt_core mwt_chk #(
  .DOM_TO_CYC(DOM_TO_CYC),
  .REM_WAKE_CYC(REM_WAKE_CYC),
  .LOC_WAKE_CYC(LOC_WAKE_CYC)
) u_chk (
  .clk_sys_i, .srst_i, .wake_pin_i, .bus_dominant_i, .txd_dominant_i,
  .req_normal_i, .mode_o, .host_rst_n_o, .wd_fault_o, .remote_wake_o,
  .local_wake_o, .tx_enable_o, .tx_drive_dominant_o, .txd_timeout_o,
  .bus_timeout_o
);

// *** verification/mwt_host.sv ***
module mwt_host (
  // Clock and host reset
  input wire logic clk_sys_i,
  input wire logic host_rst_n_i,
  // Cycles between triggers, zero stops triggering
  input wire logic [15:0] spacing_i,
  // Trigger pin
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt = 16'h0000;
  // The pin is push-pull, so it is driven low between triggers.
  always @(posedge clk_sys_i) begin
    if (!host_rst_n_i) begin
      cnt <= 16'h0000;
      trig_o <= 1'b0;
    end else begin
      if (spacing_i != 16'h0000 && cnt >= spacing_i) cnt <= 16'h0000;
      else cnt <= cnt + 16'h0001;
      trig_o <= spacing_i != 16'h0000 && cnt >= spacing_i - 16'h0008;
    end
  end
endmodule

// *** verification/test_mode_wake_watchdog_timing.sv ***
module test_mode_wake_watchdog_timing;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RES = 200;
  localparam int unsigned STC = 400;
  localparam int unsigned DTO = 300;
  localparam int unsigned RWK = 50;
  localparam int unsigned LWK = 60;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic wake = 1'b0;
  logic bus = 1'b0;
  logic txd = 1'b0;
  logic rn = 1'b0;
  logic rsl = 1'b0;
  logic rsb = 1'b0;
  logic pg = 1'b1;
  logic [15:0] spacing = 16'h0000;
  logic trig;
  logic [4:0] mode;
  logic hrst_n, flt, rwk, lwk, txen, txdd, tto, bto;
  int n_fail = 0;
  int num_checks = 0;
  int ticks = 0;
  int n;
  mwt_host i_host (.clk_sys_i, .host_rst_n_i(hrst_n), .spacing_i(spacing),
    .trig_o(trig));
  // A period of 400 cycles puts the trigger window at 150 to 250.
  mwt_core #(.RES_CYC(RES), .STARTUP_CYC(STC), .DOM_TO_CYC(DTO),
    .REM_WAKE_CYC(RWK), .LOC_WAKE_CYC(LWK)) i_dut (
    .clk_sys_i, .srst_i, .power_good_i(pg), .wake_pin_i(wake),
    .bus_dominant_i(bus), .txd_dominant_i(txd), .wd_trigger_i(trig),
    .req_normal_i(rn), .req_standby_i(rsb), .req_sleep_i(rsl),
    .periodic_supervisor_period_i(32'h0000_0190), .mode_o(mode),
    .host_rst_n_o(hrst_n), .wd_fault_o(flt), .remote_wake_o(rwk),
    .local_wake_o(lwk), .tx_enable_o(txen), .tx_drive_dominant_o(txdd),
    .txd_timeout_o(tto), .bus_timeout_o(bto));
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    ticks++;
    if (ticks == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wmode(input logic [4:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wfor(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic phase(input logic lvl, input int len);
    bus = lvl;
    cyc(len);
  endtask
  task automatic req_sleep;
    rsl = 1'b1;
    cyc(1);
    rsl = 1'b0;
    check(mode, 5'h10);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_power_up;
    wmode(5'h02, RES + 20);
    check(n >= RES && n <= RES + 8, 1'b1);
    wfor(flt, STC + 20);
    check(n >= STC - 2 && n <= STC + 2, 1'b1);
    check(mode, 5'h01);
    check(hrst_n, 1'b0);
    spacing = 16'h00C8;
    wmode(5'h04, RES + STC);
    check(mode, 5'h04);
    $display("test power up done");
  endtask
  task automatic t_normal;
    rn = 1'b1;
    cyc(1);
    rn = 1'b0;
    check(mode, 5'h08);
    cyc(1);
    check(txen, 1'b1);
    $display("test normal done");
  endtask
  task automatic t_timeouts;
    txd = 1'b1;
    cyc(DTO - 20);
    check(tto, 1'b0);
    check(txdd, 1'b1);
    wfor(tto, 40);
    check(n >= 18 && n <= 30, 1'b1);
    // Hold the input long enough for the raw-pin run check to arm.
    cyc(6);
    check(txen | txdd, 1'b0);
    txd = 1'b0;
    cyc(8);
    check(tto, 1'b0);
    bus = 1'b1;
    wfor(bto, DTO + 20);
    check(n >= DTO && n <= DTO + 8, 1'b1);
    bus = 1'b0;
    cyc(2);
    check(txen, 1'b0);
    check(mode, 5'h08);
    rsb = 1'b1;
    cyc(1);
    rsb = 1'b0;
    check(mode, 5'h04);
    $display("test timeouts done");
  endtask
  task automatic t_window;
    spacing = 16'h0064;
    wfor(flt, 300);
    check(mode, 5'h01);
    spacing = 16'h00C8;
    wmode(5'h04, RES + STC);
    spacing = 16'h0000;
    wfor(flt, 300);
    check(flt, 1'b1);
    spacing = 16'h00C8;
    wmode(5'h04, RES + STC);
    check(mode, 5'h04);
    // A supply drop must restart the whole reset delay.
    pg = 1'b0;
    cyc(6);
    check(mode, 5'h01);
    pg = 1'b1;
    wmode(5'h04, RES + STC);
    check(n > RES && n < RES + STC, 1'b1);
    $display("test window done");
  endtask
  task automatic t_remote;
    req_sleep();
    phase(1'b1, 1100);
    phase(1'b0, 500);
    phase(1'b1, 1100);
    phase(1'b0, 1100);
    phase(1'b1, 500);
    phase(1'b0, 500);
    check(mode, 5'h10);
    phase(1'b1, 990);
    wfor(rwk, 200);
    check(n >= 52 && n <= 75, 1'b1);
    bus = 1'b0;
    cyc(1);
    check(mode, 5'h01);
    wmode(5'h04, RES + 20);
    check(mode, 5'h04);
    $display("test remote wake done");
  endtask
  task automatic t_local;
    req_sleep();
    wake = 1'b1;
    cyc(100);
    wake = 1'b0;
    cyc(300);
    check(mode, 5'h10);
    wake = 1'b1;
    wfor(lwk, 300);
    check(n >= 205 && n <= 222, 1'b1);
    cyc(1);
    check(mode, 5'h01);
    wmode(5'h04, RES + 20);
    check(mode, 5'h04);
    $display("test local wake done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(10);
    srst_i = 1'b0;
    t_power_up();
    t_normal();
    t_timeouts();
    t_window();
    t_remote();
    t_local();
    give_verdict();
  end
endmodule
